// file: src/cabe_exec.sv
// Execution block for arithmetic, logic, multiply, skip and branch
`timescale 1ns/1ps
module cabe_exec
   import cabe_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic         req_valid,
   input  wire cabe_req_type req,
   output logic              req_ready,
   output logic              done,
   output cabe_res_type      res,
   output logic      [7:0]   flags
);
   cabe_state_type st_r;
   cabe_res_type   res_r;
   cabe_res_type   pend_r;
   cabe_res_type   x;
   logic [7:0]  flags_r;
   logic [7:0]  pend_flags_r;
   logic [7:0]  xf;
   logic [1:0]  xcyc;
   logic [1:0]  last_cyc_r;
   logic        done_r;
   logic [31:0] prdata_r;
   logic        err_r;
   logic        accept;
   logic        commit;
   logic        apb_wr;
   logic [15:0] seq_pc;
   logic [15:0] br_tgt;
   logic [15:0] skip_pc;
   logic [1:0]  skip_cyc;
   logic [10:0] ar;
   logic [16:0] ws;
   logic [15:0] wb;
   logic [15:0] wr;
   logic        wc;
   logic        wv;
   logic        ws_sub;
   logic [7:0]  lr;
   logic        sk;
   logic [15:0] mprod;
   logic        mcarry;
   logic        m_as;
   logic        m_bs;
   logic        m_fr;

   // {h, v, c, result}; sub computes a - b - ci with borrow as carry
   function automatic logic [10:0] alu8(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic       ci,
                                        input logic       sub);
      logic [7:0] bb;
      logic [8:0] s;
      logic [4:0] n;
      logic       cin;
      bb = sub ? ~b : b;
      cin = sub ? ~ci : ci;
      s = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
      n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
      alu8 = {n[4] ^ sub, (a[7] == bb[7]) && (s[7] != a[7]),
              s[8] ^ sub, s[7:0]};
   endfunction : alu8

   // Flags of an 8-bit arithmetic result; zkeep chains Z across bytes
   function automatic logic [7:0] arith_flags(input logic [7:0]  f,
                                              input logic [10:0] r,
                                              input logic        zkeep);
      logic [7:0] o;
      o = f;
      o[FL_H] = r[10];
      o[FL_V] = r[9];
      o[FL_C] = r[8];
      o[FL_N] = r[7];
      o[FL_Z] = (r[7:0] == 8'h00) & (~zkeep | f[FL_Z]);
      o[FL_S] = r[7] ^ r[9];
      arith_flags = o;
   endfunction : arith_flags

   // Logic results clear V and touch only Z N V S (S follows N xor V)
   function automatic logic [7:0] logic_flags(input logic [7:0] f,
                                              input logic [7:0] r);
      logic [7:0] o;
      o = f;
      o[FL_V] = 1'b0;
      o[FL_N] = r[7];
      o[FL_Z] = (r == 8'h00);
      o[FL_S] = r[7];
      logic_flags = o;
   endfunction : logic_flags

   // Branch condition for each branch form
   function automatic logic br_taken(input cabe_op_type op,
                                     input logic [7:0]  f,
                                     input logic [2:0]  s);
      case (op)
         branch_flag_set:         br_taken = f[s];
         branch_flag_clear:       br_taken = ~f[s];
         branch_equal:            br_taken = f[FL_Z];
         branch_not_equal:        br_taken = ~f[FL_Z];
         branch_same_higher:      br_taken = ~f[FL_C];
         branch_lower:            br_taken = f[FL_C];
         branch_signed_ge:        br_taken = ~(f[FL_N] ^ f[FL_V]);
         branch_signed_less:      br_taken = f[FL_N] ^ f[FL_V];
         branch_half_carry_set:   br_taken = f[FL_H];
         branch_half_carry_clear: br_taken = ~f[FL_H];
         branch_transfer_set:     br_taken = f[FL_T];
         branch_transfer_clear:   br_taken = ~f[FL_T];
         branch_overflow_set:     br_taken = f[FL_V];
         default:                 br_taken = 1'b0;
      endcase
   endfunction : br_taken

   cabe_mul u_mul (
      .a        (req.rd),
      .b        (req.rr),
      .a_signed (m_as),
      .b_signed (m_bs),
      .frac     (m_fr),
      .product  (mprod),
      .carry    (mcarry)
   );

   assign req_ready = (st_r == st_idle);
   assign accept = req_valid & req_ready;
   assign commit = (accept & (xcyc == CYC_1)) | (st_r == st_wait1);

   always_comb
   begin
      seq_pc = req.pc + 16'h0001;
      br_tgt = seq_pc + {{9{req.koff[6]}}, req.koff};
      skip_pc = seq_pc + {14'h0000, req.skip_words};
      skip_cyc = CYC_1 + req.skip_words;
      m_as = (req.op == product_signed) | (req.op == product_mixed_sign) |
             (req.op == fraction_product_signed) |
             (req.op == fraction_product_mixed);
      m_bs = (req.op == product_signed) |
             (req.op == fraction_product_signed);
      m_fr = (req.op == fraction_product_unsigned) |
             (req.op == fraction_product_signed) |
             (req.op == fraction_product_mixed);
   end

   // Word add and subtract on a register pair
   always_comb
   begin
      ws_sub = (req.op == pair_minus_immediate);
      wb = ws_sub ? ~{8'h00, req.imm} : {8'h00, req.imm};
      ws = {1'b0, req.pair} + {1'b0, wb} + {16'h0000, ws_sub};
      wr = ws[15:0];
      wc = ws[16] ^ ws_sub;
      wv = (req.pair[15] == wb[15]) && (wr[15] != req.pair[15]);
   end

   always_comb
   begin
      x.dest = dst_none;
      x.data = 16'h0000;
      x.pc = seq_pc;
      xf = flags_r;
      xcyc = CYC_1;
      ar = 11'h000;
      lr = 8'h00;
      sk = 1'b0;
      case (req.op)
         add_regs, add_carry:
         begin
            ar = alu8(req.rd, req.rr, (req.op == add_carry) & flags_r[FL_C],
                      1'b0);
            x.dest = dst_rd;
            x.data = {8'h00, ar[7:0]};
            xf = arith_flags(flags_r, ar, 1'b0);
         end
         sub_regs, minus_constant, minus_with_borrow,
         minus_constant_with_borrow, compare_regs, compare_with_borrow,
         compare_immediate:
         begin
            ar = alu8(req.rd,
                      (req.op == minus_constant |
                       req.op == minus_constant_with_borrow |
                       req.op == compare_immediate) ? req.imm : req.rr,
                      flags_r[FL_C] & (req.op == minus_with_borrow |
                       req.op == minus_constant_with_borrow |
                       req.op == compare_with_borrow), 1'b1);
            // Compares leave the destination alone
            x.dest = (req.op == compare_regs | req.op == compare_immediate |
                      req.op == compare_with_borrow) ? dst_none :
                     dst_rd;
            x.data = {8'h00, ar[7:0]};
            xf = arith_flags(flags_r, ar, req.op == minus_with_borrow |
                             req.op == minus_constant_with_borrow |
                             req.op == compare_with_borrow);
         end
         pair_plus_immediate, pair_minus_immediate:
         begin
            x.dest = dst_pair;
            x.data = wr;
            xf[FL_Z] = (wr == 16'h0000);
            xf[FL_C] = wc;
            xf[FL_N] = wr[15];
            xf[FL_V] = wv;
            xf[FL_S] = wr[15] ^ wv;
            xcyc = CYC_2;
         end
         conj_regs, conj_with_constant, disj_regs, disj_with_constant,
         exclusive_disj, set_register_bits, clear_register_bits,
         zero_minus_check:
         begin
            case (req.op)
               conj_regs:           lr = req.rd & req.rr;
               conj_with_constant:  lr = req.rd & req.imm;
               disj_regs:           lr = req.rd | req.rr;
               disj_with_constant:  lr = req.rd | req.imm;
               exclusive_disj:      lr = req.rd ^ req.rr;
               set_register_bits:   lr = req.rd | req.imm;
               clear_register_bits: lr = req.rd & (BYTE_ONES-req.imm);
               default:             lr = req.rd & req.rd;
            endcase
            x.dest = dst_rd;
            x.data = {8'h00, lr};
            xf = logic_flags(flags_r, lr);
         end
         product_unsigned, product_signed, product_mixed_sign,
         fraction_product_unsigned, fraction_product_signed,
         fraction_product_mixed:
         begin
            x.dest = dst_r1r0;
            x.data = mprod;
            xf[FL_Z] = (mprod == 16'h0000);
            xf[FL_C] = mcarry;
            xcyc = CYC_2;
         end
         pointer_jump:
         begin
            x.pc = req.zptr;
            xcyc = CYC_2;
         end
         pointer_call:
         begin
            x.pc = req.zptr;
            xcyc = CYC_3;
         end
         equal_skip, skip_reg_bit_clear, skip_reg_bit_set,
         skip_io_bit_clear, skip_io_bit_set:
         begin
            case (req.op)
               equal_skip:         sk = (req.rd == req.rr);
               skip_reg_bit_clear: sk = ~req.rr[req.bsel];
               skip_reg_bit_set:   sk = req.rr[req.bsel];
               skip_io_bit_clear:  sk = ~req.io_bit;
               default:            sk = req.io_bit;
            endcase
            x.pc = sk ? skip_pc : seq_pc;
            xcyc = sk ? skip_cyc : CYC_1;
         end
         default:
         begin
            if (br_taken(req.op, flags_r, req.bsel))
            begin
               x.pc = br_tgt;
               xcyc = CYC_2;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         st_r <= st_idle;
      else
      begin
         case (st_r)
            st_idle:
            begin
               if (accept && xcyc == CYC_2)
                  st_r <= st_wait1;
               else if (accept && xcyc == CYC_3)
                  st_r <= st_wait2;
            end
            st_wait2: st_r <= st_wait1;
            st_wait1: st_r <= st_idle;
            default:  st_r <= st_idle;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pend_r <= '0;
         pend_flags_r <= FLAGS_RST;
         last_cyc_r <= CYC_1;
      end
      else if (accept)
      begin
         pend_r <= x;
         pend_flags_r <= xf;
         last_cyc_r <= xcyc;
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         res_r <= '{dest: dst_none, data: 16'h0000, pc: PC_RST};
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= commit;
         if (commit)
            res_r <= (st_r == st_idle) ? x : pend_r;
      end
   end

   // Core update wins over a software write in the same cycle
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         flags_r <= FLAGS_RST;
      else if (commit)
         flags_r <= (st_r == st_idle) ? xf : pend_flags_r;
      else if (apb_wr)
         flags_r <= pwdata[7:0];
   end

   assign apb_wr = psel & penable & pwrite & (paddr == A_FLAGS);

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         prdata_r <= 32'h0000_0000;
         err_r <= 1'b0;
      end
      else if (psel && !penable)
      begin
         err_r <= 1'b0;
         case (paddr)
            A_FLAGS: prdata_r <= {24'h000000, flags_r};
            A_PC:    prdata_r <= {16'h0000, res_r.pc};
            A_STAT:  prdata_r <= {29'h00000000, last_cyc_r, ~req_ready};
            default:
            begin
               prdata_r <= 32'h0000_0000;
               err_r <= 1'b1;
            end
         endcase
      end
   end

   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = psel & penable & err_r;
   assign done = done_r;
   assign res = res_r;
   assign flags = flags_r;

   logic [15:0] h_tgt;
   logic        h_one;
   assign h_tgt = req.pc + {{9{req.koff[6]}}, req.koff} + 16'h0001;
   assign h_one = accept & (xcyc == CYC_1);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   property p_one_cycle;
      h_one |=> done_r && req_ready;
   endproperty
   a_one_cycle: assert property (p_one_cycle)
      else $error("one-cycle op did not complete next cycle");

   property p_pair;
      accept && req.op == pair_plus_immediate |=>
         !done_r ##1 done_r && res_r.dest == dst_pair;
   endproperty
   a_pair: assert property (p_pair)
      else $error("pair add not done in two cycles");

   property p_mul;
      accept && req.op == product_unsigned |=>
         !req_ready ##1 done_r && res_r.dest == dst_r1r0 &&
         flags_r[FL_C] == res_r.data[15];
   endproperty
   a_mul: assert property (p_mul)
      else $error("product timing or carry wrong");

   property p_logic_v;
      accept && req.op == exclusive_disj |=>
         done_r && !flags_r[FL_V] && flags_r[FL_C] == $past(flags_r[FL_C]) &&
         flags_r[FL_Z] == (res_r.data[7:0] == 8'h00);
   endproperty
   a_logic_v: assert property (p_logic_v)
      else $error("logic flags wrong");

   property p_br_taken;
      accept && req.op == branch_equal && flags_r[FL_Z] |=>
         !done_r ##1 done_r && res_r.pc == $past(h_tgt, 2);
   endproperty
   a_br_taken: assert property (p_br_taken)
      else $error("taken branch target or timing wrong");

   property p_br_not;
      accept && req.op == branch_signed_ge &&
         flags_r[FL_N] != flags_r[FL_V] |=>
         done_r && res_r.pc == $past(req.pc) + 16'h0001;
   endproperty
   a_br_not: assert property (p_br_not)
      else $error("untaken branch wrong");

   property p_jump_flags;
      accept && req.op == pointer_jump |=>
         $stable(flags_r) ##1 done_r && res_r.pc == $past(req.zptr, 2);
   endproperty
   a_jump_flags: assert property (p_jump_flags)
      else $error("pointer jump wrong");

   property p_skip2;
      accept && req.op == equal_skip && req.rd == req.rr &&
         req.skip_words == 2'h2 |=>
         !done_r [*2] ##1 done_r && res_r.pc == $past(skip_pc, 3);
   endproperty
   a_skip2: assert property (p_skip2)
      else $error("two-word skip wrong");

   property p_call;
      accept && req.op == pointer_call |=> !req_ready [*2] ##1 req_ready;
   endproperty
   a_call: assert property (p_call)
      else $error("pointer call not three cycles");

   c_mul: cover property (accept && req.op == fraction_product_signed);
   c_br: cover property (accept && req.op == branch_flag_set && xcyc == CYC_2);
   c_skip: cover property (accept && req.op == skip_io_bit_set && sk);
   c_apb: cover property (apb_wr ##2 accept);
endmodule : cabe_exec

// file: src/cabe_mul.sv
// Combinational multiplier datapath with signed and fractional modes
`timescale 1ns/1ps
module cabe_mul
   import cabe_pkg::*;
(
   input  wire logic [7:0]  a,
   input  wire logic [7:0]  b,
   input  wire logic        a_signed,
   input  wire logic        b_signed,
   input  wire logic        frac,
   output logic      [15:0] product,
   output logic             carry
);
   logic signed [17:0] full;
   logic        [15:0] raw;

   always_comb
   begin
      full = $signed({a_signed & a[7], a}) *
             $signed({b_signed & b[7], b});
      raw = full[15:0];
      // Carry is the top product bit before any fraction shift
      carry = raw[15];
      product = frac ? {raw[14:0], 1'b0} : raw;
   end
endmodule : cabe_mul

// file: src/cabe_pkg.sv
// Constants and types of the ALU and branch execution block
// Overview of operation
// - Add and add-with-carry write 8-bit sum, set Z C N V H, one cycle
// - Pair plus immediate: 16-bit sum to pair, Z C N V S, two cycles
// - Subtract register or constant, with borrow, Z C N V H, one cycle
// - Pair minus immediate: 16-bit result to pair, Z C N V S, two cycles
// - Conjunction with register or constant sets only Z N V S, one cycle
// - Disjunction and exclusive disjunction set only Z N V S, one cycle
// - Bit clear ands with 0xff minus constant, sets Z N V S only
// - Bit set ors constant into register, sets Z N V, one cycle
// - Test ands register with itself, sets Z N V, one cycle
// - Three integer products go to R1:R0, set Z C, two cycles
// - Fraction products shift left one into R1:R0, set Z C, two cycles
// - Pointer jump loads PC from Z pointer, keeps flags, two cycles
// - Pointer call loads PC from Z pointer, keeps flags
// - Equal skip jumps past next instruction when equal, flags kept
// - Compares subtract without storing, set Z N V C H
// - Register bit skips act when selected bit is clear or set
// - I/O bit skips act when addressed bit is 0 or 1
// - Generic branch on chosen flag: PC plus offset plus one, 1/2 cycles
// - Signed branches test N xor V for 0 or 1
// - Same-or-higher on C=0, lower on C=1; equal tests Z likewise
// - Half-carry branches taken when H is 1 or 0 as selected
// - Transfer branches test T; overflow branch taken when V is 1
package cabe_pkg;
   localparam int FL_C = 0;
   localparam int FL_Z = 1;
   localparam int FL_N = 2;
   localparam int FL_V = 3;
   localparam int FL_S = 4;
   localparam int FL_H = 5;
   localparam int FL_T = 6;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [7:0] BYTE_ONES = 8'hff;
   localparam logic [7:0] A_FLAGS = 8'h00;
   localparam logic [7:0] A_PC = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [1:0] CYC_1 = 2'h1;
   localparam logic [1:0] CYC_2 = 2'h2;
   localparam logic [1:0] CYC_3 = 2'h3;

   typedef enum logic [5:0] {
      add_regs, add_carry, pair_plus_immediate, sub_regs,
      minus_constant, minus_with_borrow, minus_constant_with_borrow,
      pair_minus_immediate, conj_regs, conj_with_constant, disj_regs,
      disj_with_constant, exclusive_disj, set_register_bits,
      clear_register_bits, zero_minus_check, product_unsigned,
      product_signed, product_mixed_sign, fraction_product_unsigned,
      fraction_product_signed, fraction_product_mixed, pointer_jump,
      pointer_call, equal_skip, compare_regs, compare_with_borrow,
      compare_immediate, skip_reg_bit_clear, skip_reg_bit_set,
      skip_io_bit_clear, skip_io_bit_set, branch_flag_set,
      branch_flag_clear, branch_equal, branch_not_equal,
      branch_same_higher, branch_lower, branch_signed_ge,
      branch_signed_less, branch_half_carry_set, branch_half_carry_clear,
      branch_transfer_set, branch_transfer_clear, branch_overflow_set
   } cabe_op_type;

   typedef enum logic [1:0] {
      st_idle  = 2'b00,
      st_wait2 = 2'b01,
      st_wait1 = 2'b11
   } cabe_state_type;

   typedef enum logic [1:0] {
      dst_none, dst_rd, dst_pair, dst_r1r0
   } cabe_dest_type;

   typedef struct packed {
      cabe_op_type op;
      logic [7:0]  rd;
      logic [7:0]  rr;
      logic [7:0]  imm;
      logic [15:0] pair;
      logic [15:0] zptr;
      logic [15:0] pc;
      logic [2:0]  bsel;
      logic        io_bit;
      logic [6:0]  koff;
      logic [1:0]  skip_words;
   } cabe_req_type;

   typedef struct packed {
      cabe_dest_type dest;
      logic [15:0]   data;
      logic [15:0]   pc;
   } cabe_res_type;
endpackage : cabe_pkg

// file: verification/cabe_core_model.sv
// Core-side model: issues execution requests and times their completion
`timescale 1ns/1ps
module cabe_core_model
   import cabe_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         req_ready,
   input  wire logic         done,
   output logic              req_valid,
   output cabe_req_type      req
);
   initial
   begin
      req_valid = 1'b0;
      req       = '0;
   end

   task automatic issue(input cabe_req_type r, output int n);
      @(posedge clk);
      req_valid <= 1'b1;
      req       <= r;
      #1;
      while (req_ready !== 1'b1)
      begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
      req_valid <= 1'b0;
      // Released request lines no longer show the last value
      req       <= cabe_req_type'(~r);
      n = 1;
      #1;
      while (done !== 1'b1 && n < 8)
      begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask : issue
endmodule : cabe_core_model

// file: verification/cabe_exec_bench.sv
// Self-checking bench for the execution block
`timescale 1ns/1ps
module cabe_exec_bench
   import cabe_pkg::*;
   ;
   logic         clk = 1'b0;
   logic         reset_n = 1'b0;
   logic         psel = 1'b0;
   logic         penable = 1'b0;
   logic         pwrite = 1'b0;
   logic [7:0]   paddr = 8'h00;
   logic [31:0]  pwdata = 32'h0;
   logic [31:0]  prdata, rd_q;
   logic         pready, pslverr, err_q, req_valid, req_ready, done;
   logic [7:0]   flags;
   cabe_req_type req, r;
   cabe_res_type res;
   int           miscompares = 0;
   int           tests_run = 0;
   int           n;

   always #50 clk = ~clk;

   cabe_exec dut_u (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req_valid(req_valid), .req(req), .req_ready(req_ready),
      .done(done), .res(res), .flags(flags));
   cabe_core_model core_u (.clk(clk), .req_ready(req_ready), .done(done),
      .req_valid(req_valid), .req(req));

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask : chk

   task automatic close_out();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic cabe_req_type base(input cabe_op_type o);
      cabe_req_type b;
      b = '0;
      b.op = o;
      b.pc = 16'h0100;
      b.skip_words = 2'h1;
      return b;
   endfunction : base

   task automatic go(input logic [15:0] d, input logic [7:0] f,
                     input logic [15:0] p, input int c,
                     input cabe_dest_type ds);
      core_u.issue(r, n);
      chk("cycles", c, n);
      chk("flags", f, flags);
      chk("pc", p, res.pc);
      chk("dest", ds, res.dest);
      if (ds == dst_rd)
         chk("data", d[7:0], res.data[7:0]);
      else if (ds != dst_none)
         chk("data", d, res.data);
   endtask : go

   // Preset flags, then run one op with operands packed as flags,rd,rr,imm
   task automatic ar(input cabe_op_type o, input logic [31:0] v,
                     input logic [15:0] d, input logic [7:0] f,
                     input int c, input cabe_dest_type ds);
      apb(1'b1, A_FLAGS, {24'h0, v[31:24]});
      r = base(o);
      r.rd = v[23:16];
      r.rr = v[15:8];
      r.imm = v[7:0];
      r.pair = v[23:8];
      go(d, f, 16'h0101, c, ds);
   endtask : ar

   task automatic lg(input cabe_op_type o, input logic [23:0] v,
                     input logic [7:0] e);
      ar(o, {8'h21, v}, {8'h0, e},
         {2'b00, 1'b1, e[7], 1'b0, e[7], e == 8'h00, 1'b1}, 1, dst_rd);
   endtask : lg

   task automatic ml(input cabe_op_type o, input logic [15:0] v,
                     input logic [15:0] p, input logic c);
      ar(o, {8'h44, v, 8'h00}, p, 8'h44 | {6'h0, p == 16'h0, c}, 2,
         dst_r1r0);
   endtask : ml

   task automatic fl(input cabe_op_type o, input logic [15:0] v,
                     input logic io, input logic [1:0] sw,
                     input logic [15:0] p, input int c);
      apb(1'b1, A_FLAGS, 32'h2a);
      r = base(o);
      {r.rd, r.rr} = v;
      r.zptr = 16'h1234;
      r.bsel = 3'h2;
      r.io_bit = io;
      r.skip_words = sw;
      go(16'h0, 8'h2a, p, c, dst_none);
   endtask : fl

   task automatic br(input cabe_op_type o, input logic [2:0] s,
                     input logic [6:0] k, input logic t);
      apb(1'b1, A_FLAGS, 32'h6a);
      r = base(o);
      r.bsel = s;
      r.koff = k;
      go(16'h0, 8'h6a, t ? 16'h0101 + {{9{k[6]}}, k} : 16'h0101,
         t ? 2 : 1, dst_none);
   endtask : br

   task automatic t_regs();
      chk("flags_rst", 8'h00, flags);
      chk("pc_rst", 16'h0000, res.pc);
      apb(1'b0, A_FLAGS, 32'h0);
      chk("rd_flags", 32'h0, rd_q);
      apb(1'b1, A_FLAGS, 32'h5a);
      apb(1'b0, A_FLAGS, 32'h0);
      chk("wr_flags", 32'h5a, rd_q);
      chk("err_ok", 1'b0, err_q);
      apb(1'b0, 8'h0c, 32'h0);
      chk("err_unmapped", 1'b1, err_q);
   endtask : t_regs

   task automatic t_alu();
      ar(add_regs, 32'h407f0100, 16'h0080, 8'h6c, 1, dst_rd);
      ar(add_carry, 32'h01ff0000, 16'h0000, 8'h23, 1, dst_rd);
      ar(sub_regs, 32'h00000100, 16'h00ff, 8'h35, 1, dst_rd);
      ar(minus_constant, 32'h40100001, 16'h000f, 8'h60, 1, dst_rd);
      ar(minus_with_borrow, 32'h01010000, 16'h0, 8'h00, 1, dst_rd);
      ar(minus_constant_with_borrow, 32'h03050004, 16'h0, 8'h02, 1,
         dst_rd);
      ar(compare_regs, 32'h00333300, 16'h0, 8'h02, 1, dst_none);
      ar(compare_with_borrow, 32'h01000000, 16'h0, 8'h35, 1,
         dst_none);
      ar(compare_immediate, 32'h40100020, 16'h0, 8'h55, 1,
         dst_none);
      ar(pair_plus_immediate, 32'h20ffff01, 16'h0, 8'h23, 2,
         dst_pair);
      ar(pair_minus_immediate, 32'h40000001, 16'hffff, 8'h55, 2,
         dst_pair);
   endtask : t_alu

   task automatic t_logic();
      lg(conj_regs, 24'hf08000, 8'h80);
      lg(conj_with_constant, 24'h0f00f0, 8'h00);
      lg(disj_regs, 24'h018000, 8'h81);
      lg(disj_with_constant, 24'h100001, 8'h11);
      lg(exclusive_disj, 24'h5a5a00, 8'h00);
      lg(set_register_bits, 24'h010080, 8'h81);
      lg(clear_register_bits, 24'hff000f, 8'hf0);
      lg(zero_minus_check, 24'h808000, 8'h80);
   endtask : t_logic

   task automatic t_mul();
      ml(product_unsigned, 16'hffff, 16'hfe01, 1'b1);
      ml(product_unsigned, 16'h005a, 16'h0000, 1'b0);
      ml(product_signed, 16'hffff, 16'h0001, 1'b0);
      ml(product_mixed_sign, 16'hff02, 16'hfffe, 1'b1);
      ml(fraction_product_unsigned, 16'h8080, 16'h8000, 1'b0);
      ml(fraction_product_signed, 16'h8080, 16'h8000, 1'b0);
      ml(fraction_product_mixed, 16'hff80, 16'hff00, 1'b1);
   endtask : t_mul

   task automatic t_flow();
      fl(pointer_jump, 16'h0, 1'b0, 2'h1, 16'h1234, 2);
      fl(pointer_call, 16'h0, 1'b0, 2'h1, 16'h1234, 3);
      fl(equal_skip, 16'h3333, 1'b0, 2'h2, 16'h0103, 3);
      fl(equal_skip, 16'h3334, 1'b0, 2'h2, 16'h0101, 1);
      fl(skip_reg_bit_set, 16'h0004, 1'b0, 2'h1, 16'h0102, 2);
      fl(skip_reg_bit_clear, 16'h0004, 1'b0, 2'h1, 16'h0101, 1);
      fl(skip_io_bit_clear, 16'h0, 1'b0, 2'h2, 16'h0103, 3);
      fl(skip_io_bit_set, 16'h0, 1'b0, 2'h2, 16'h0101, 1);
      fl(skip_io_bit_set, 16'h0, 1'b1, 2'h1, 16'h0102, 2);
   endtask : t_flow

   task automatic t_branch();
      br(branch_equal, 3'h0, 7'h7e, 1'b1);
      br(branch_not_equal, 3'h0, 7'h7e, 1'b0);
      br(branch_same_higher, 3'h0, 7'h3f, 1'b1);
      br(branch_lower, 3'h0, 7'h7e, 1'b0);
      br(branch_signed_ge, 3'h0, 7'h7e, 1'b0);
      br(branch_signed_less, 3'h0, 7'h40, 1'b1);
      br(branch_half_carry_set, 3'h0, 7'h7e, 1'b1);
      br(branch_half_carry_clear, 3'h0, 7'h7e, 1'b0);
      br(branch_transfer_set, 3'h0, 7'h7e, 1'b1);
      br(branch_transfer_clear, 3'h0, 7'h7e, 1'b0);
      br(branch_overflow_set, 3'h0, 7'h7e, 1'b1);
      br(branch_flag_set, 3'h0, 7'h7e, 1'b0);
      br(branch_flag_clear, 3'h0, 7'h7e, 1'b1);
      br(branch_flag_set, 3'h6, 7'h7e, 1'b1);
      apb(1'b1, A_PC, 32'hffff);
      apb(1'b0, A_PC, 32'h0);
      chk("pc_reg", 32'h00ff, rd_q);
   endtask : t_branch

   initial
   begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      #1;
      t_regs();
      t_alu();
      t_logic();
      t_mul();
      t_flow();
      t_branch();
      close_out();
   end

   initial
   begin
      #(100 * 5000);
      miscompares++;
      close_out();
   end
endmodule : cabe_exec_bench
